// ==== src/wgt_pkg.sv ====
/*
 * Constants and carrier types for the windowed guard timer.
 * Assumes a 32-bit classic Wishbone slave port and one clock.
 */
package wgt_pkg;

	localparam int CNT_W = 14;
	localparam int DIV_W = 15;
	localparam int SLOW_W = 2;

	localparam logic [4:0] ADR_CONTROL = 5'h00;
	localparam logic [4:0] ADR_CONFIG = 5'h04;
	localparam logic [4:0] ADR_FLAGS = 5'h08;
	localparam logic [4:0] ADR_IRQ_STAT = 5'h0c;
	localparam logic [4:0] ADR_IRQ_MASK = 5'h10;

	localparam int ARM_BIT = 14;
	localparam int EWI_EN_BIT = 16;
	localparam int SLOW_LSB = 14;
	localparam int IRQ_N = 3;
	localparam int EV_EARLY = 0;
	localparam int EV_WINDOW = 1;
	localparam int EV_UNDER = 2;

	localparam logic [CNT_W-1:0] CNT_RESET = 14'h3fff;
	localparam logic [CNT_W-1:0] WIN_RESET = 14'h3fff;
	localparam logic [CNT_W-1:0] CNT_WARN = 14'h0040;
	localparam logic [CNT_W-1:0] CNT_PRE_WARN = 14'h0041;

	localparam logic [DIV_W-1:0] BASE_DIV = 15'h1000;

	typedef struct packed {
		logic ewi_en;
		logic [SLOW_W-1:0] slow;
		logic [CNT_W-1:0] window;
	} wgt_cfg_s;

	localparam wgt_cfg_s CFG_RESET = '{
		ewi_en: 1'b0,
		slow: 2'h0,
		window: WIN_RESET
	};

endpackage : wgt_pkg

// ==== src/wgt_top.sv ====
/*
 * Windowed guard timer: prescaler, 14-bit down-counter, window
 * check, early warning and a classic Wishbone register slave.
 * Assumes all inputs are synchronous to core_clk and that the
 * system reset controller returns rst after a reset request.
 */
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) Decrement once per 4096 times two-power-select cycles
// (RULE_02) Armed: reset request on 0x40 to 0x3F
// (RULE_03) Armed: reset request on refresh above limit
// (RULE_04) Arm latch bit 14 is set-only
// (RULE_05) Counter runs whether armed or not
// (RULE_06) Early warning flag set on reaching 0x40
// (RULE_07) Early warning flag cleared by writing zero
// (RULE_08) Enabled interrupt fires on reaching 0x40
// (RULE_09) Early warning enable bit 16 set-only
// (RULE_10) Refresh limit in config bits 13:0
// (RULE_11) Control bits 13:0 read and load counter
// (RULE_12) Slowdown select 15:14 divides by 1,2,4,8
// (RULE_13) Timeout spans count minus 0x40 plus one ticks
// (RULE_14) Debug halt with freeze input holds counter
// (RULE_15) Software loads bits 13:6 before arming
// (RULE_16) Software refreshes only inside the window
// (RULE_17) Window check uses count before the write
// (RULE_18) Reset request is one pulse, then quiet
module wgt_top
	import wgt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cpu_halted,
	input wire logic debug_freeze,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	output logic sys_reset_req
);

	logic [CNT_W-1:0] count;
	logic arm_latch;
	wgt_cfg_s cfg;
	logic early_warn_flag;
	logic [IRQ_N-1:0] irq_status;
	logic [IRQ_N-1:0] irq_mask;
	logic [DIV_W-1:0] prescale;
	logic req_done;

	logic bus_req;
	logic wr_en;
	logic rd_en;
	logic hit_ctrl;
	logic hit_cfg;
	logic hit_flags;
	logic hit_stat;
	logic hit_mask;
	logic count_load;
	logic [CNT_W-1:0] load_value;
	logic frozen;
	logic tick;
	logic [DIV_W-1:0] div_last;
	logic reach_warn;
	logic underflow;
	logic window_err;
	logic [IRQ_N-1:0] events;
	logic next_req;
	logic next_irq;
	logic [31:0] next_rdata;
	logic [DIV_W-1:0] next_prescale;
	logic [CNT_W-1:0] next_count;
	logic wr_ctrl_lo;
	logic wr_ctrl_hi;
	logic wr_cfg_lo;
	logic wr_cfg_hi;
	logic wr_cfg_top;
	logic wr_flags;
	logic wr_mask;
	logic rd_stat;

	// A request is taken once; ack drops the cycle after it rises
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = bus_req && wb_we_i;
	assign rd_en = bus_req && !wb_we_i;

	assign hit_ctrl = wb_adr_i == ADR_CONTROL;
	assign hit_cfg = wb_adr_i == ADR_CONFIG;
	assign hit_flags = wb_adr_i == ADR_FLAGS;
	assign hit_stat = wb_adr_i == ADR_IRQ_STAT;
	assign hit_mask = wb_adr_i == ADR_IRQ_MASK;

	// Byte lanes of each writable register
	assign wr_ctrl_lo = wr_en && hit_ctrl && wb_sel_i[0];
	assign wr_ctrl_hi = wr_en && hit_ctrl && wb_sel_i[1];
	assign wr_cfg_lo = wr_en && hit_cfg && wb_sel_i[0];
	assign wr_cfg_hi = wr_en && hit_cfg && wb_sel_i[1];
	assign wr_cfg_top = wr_en && hit_cfg && wb_sel_i[2];
	assign wr_flags = wr_en && hit_flags && wb_sel_i[0];
	assign wr_mask = wr_en && hit_mask && wb_sel_i[0];
	assign rd_stat = rd_en && hit_stat;

	// Either low byte of the control word reloads the counter
	assign count_load = wr_ctrl_lo || wr_ctrl_hi;

	always_comb begin
		load_value = count;
		if (wb_sel_i[0]) begin
			load_value[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			load_value[13:8] = wb_dat_i[13:8];
		end
	end

	// Besides clk_en low, counting stops only when the core is halted and freeze is set
	assign frozen = cpu_halted && debug_freeze; // [RULE_14]

	// Period is the 4096 base shifted by the slowdown select
	assign div_last = (BASE_DIV << cfg.slow) - 15'h0001; // [RULE_12]
	assign tick = !frozen && prescale == div_last; // [RULE_01]

	// Greater-or-equal catches a slowdown change that shortens the period
	always_comb begin
		next_prescale = prescale + 15'h0001; // [RULE_01]
		if (prescale >= div_last) begin
			next_prescale = '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prescale <= '0;
		end else if (clk_en && !frozen) begin
			prescale <= next_prescale;
		end
	end

	// A load in the tick cycle wins; the tick is simply dropped
	always_comb begin
		next_count = count;
		if (count_load) begin
			next_count = load_value; // [RULE_11]
		end else if (tick) begin
			next_count = count - 14'h0001; // [RULE_05] [RULE_13]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= CNT_RESET;
		end else if (clk_en) begin
			count <= next_count;
		end
	end

	// Events of the counting path
	assign reach_warn = tick && !count_load && count == CNT_PRE_WARN;
	assign underflow = tick && !count_load && count == CNT_WARN;
	// Compare against the count held before this write lands
	assign window_err = count_load && count > cfg.window; // [RULE_17]

	assign events[EV_EARLY] = reach_warn;
	assign events[EV_WINDOW] = window_err;
	assign events[EV_UNDER] = underflow;

	// Arm latch and enable can only be set; rst alone clears them
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arm_latch <= 1'b0;
		end else if (clk_en && wr_ctrl_hi) begin
			if (wb_dat_i[ARM_BIT]) begin
				arm_latch <= 1'b1; // [RULE_04]
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg <= CFG_RESET;
		end else if (clk_en) begin
			if (wr_cfg_lo) begin
				cfg.window[7:0] <= wb_dat_i[7:0]; // [RULE_10]
			end
			if (wr_cfg_hi) begin
				cfg.window[13:8] <= wb_dat_i[13:8]; // [RULE_10]
				cfg.slow <= wb_dat_i[SLOW_LSB +: SLOW_W]; // [RULE_12]
			end
			if (wr_cfg_top && wb_dat_i[EWI_EN_BIT]) begin
				cfg.ewi_en <= 1'b1; // [RULE_09]
			end
		end
	end

	// Hardware set beats a simultaneous write of zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			early_warn_flag <= 1'b0;
		end else if (clk_en) begin
			if (reach_warn) begin
				early_warn_flag <= 1'b1; // [RULE_06]
			end else if (wr_flags) begin
				if (!wb_dat_i[0]) begin
					early_warn_flag <= 1'b0; // [RULE_07]
				end
			end
		end
	end

	// Sticky event bits; a read clears them but new events win
	generate
		for (genvar i = 0; i < IRQ_N; i++) begin : g_stat
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					irq_status[i] <= 1'b0;
				end else if (clk_en) begin
					if (events[i]) begin
						irq_status[i] <= 1'b1;
					end else if (rd_stat) begin
						irq_status[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Mask bits follow the same layout as the status bits
	generate
		for (genvar j = 0; j < IRQ_N; j++) begin : g_mask
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					irq_mask[j] <= 1'b0;
				end else if (clk_en && wr_mask) begin
					irq_mask[j] <= wb_dat_i[j];
				end
			end
		end
	endgenerate

	// Early warning interrupt stays up until the flag is cleared
	always_comb begin
		next_irq = |(irq_status & irq_mask);
		if (cfg.ewi_en && early_warn_flag) begin
			next_irq = 1'b1; // [RULE_08]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= next_irq;
		end
	end

	// Only one pulse per reset: the controller is expected to reset us
	always_comb begin
		next_req = 1'b0;
		if (arm_latch && !req_done) begin
			if (underflow) begin
				next_req = 1'b1; // [RULE_02]
			end
			if (window_err) begin
				next_req = 1'b1; // [RULE_03]
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sys_reset_req <= 1'b0;
			req_done <= 1'b0;
		end else if (clk_en) begin
			sys_reset_req <= next_req; // [RULE_18]
			if (next_req) begin
				req_done <= 1'b1; // [RULE_18]
			end
		end
	end

	// Unmapped addresses still answer, with zero data
	always_comb begin
		next_rdata = '0;
		unique case (wb_adr_i)
			ADR_CONTROL: begin
				next_rdata[CNT_W-1:0] = count; // [RULE_11]
				next_rdata[ARM_BIT] = arm_latch; // [RULE_04]
			end
			ADR_CONFIG: begin
				next_rdata[EWI_EN_BIT:0] = cfg; // [RULE_10]
			end
			ADR_FLAGS: begin
				next_rdata[0] = early_warn_flag; // [RULE_06]
			end
			ADR_IRQ_STAT: begin
				next_rdata[IRQ_N-1:0] = irq_status;
			end
			ADR_IRQ_MASK: begin
				next_rdata[IRQ_N-1:0] = irq_mask;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// Ack is one pulse; a request still held while ack is up is not retaken
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else if (clk_en) begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data keeps its last value between reads
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (clk_en && rd_en) begin
			wb_dat_o <= next_rdata;
		end
	end

endmodule : wgt_top

// ==== sim/wgt_monitor.sv ====
/* Checker for the guard timer bus answers and reset request.
 Sees only the ports of wgt_top; bound into every instance. */
`timescale 1ns/1ps
module wgt_monitor
	import wgt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq,
	input wire logic sys_reset_req
);
	logic [4:0] l_adr;
	logic l_we, arm_seen, ewi_seen, req_seen, rd;
	assign rd = wb_ack_o && !l_we;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Keep the taken request so its answer can be judged
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			l_adr <= '0;
			l_we <= 1'b1;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en) begin
			l_adr <= wb_adr_i;
			l_we <= wb_we_i;
		end
	end
	// Set-only bits: once seen high they must read high until reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arm_seen <= 1'b0;
			ewi_seen <= 1'b0;
			req_seen <= 1'b0;
		end else begin
			if (rd && l_adr == ADR_CONTROL && wb_dat_o[ARM_BIT])
				arm_seen <= 1'b1;
			if (rd && l_adr == ADR_CONFIG && wb_dat_o[EWI_EN_BIT])
				ewi_seen <= 1'b1;
			if (sys_reset_req)
				req_seen <= 1'b1;
		end
	end
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
		clk_en |=> wb_ack_o) else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack too long");
	a_req_once: assert property (sys_reset_req |-> !req_seen)
		else $error("second reset request");
	a_ctl_width: assert property (rd && l_adr == ADR_CONTROL |->
		wb_dat_o[31:15] == 17'h0) else $error("control upper bits");
	a_cfg_width: assert property (rd && l_adr == ADR_CONFIG |->
		wb_dat_o[31:17] == 15'h0) else $error("config upper bits");
	a_flag_width: assert property (rd && l_adr == ADR_FLAGS |->
		wb_dat_o[31:1] == 31'h0) else $error("flags upper bits");
	a_arm_sticky: assert property (rd && l_adr == ADR_CONTROL &&
		arm_seen |-> wb_dat_o[ARM_BIT]) else $error("arm latch lost");
	a_ewi_sticky: assert property (rd && l_adr == ADR_CONFIG &&
		ewi_seen |-> wb_dat_o[EWI_EN_BIT]) else $error("enable lost");
	c_reset_req: cover property (sys_reset_req);
	c_irq_rise: cover property ($rose(irq));
	c_flag_read: cover property (rd && l_adr == ADR_FLAGS && wb_dat_o[0]);
endmodule : wgt_monitor

bind wgt_top wgt_monitor u_mon (.core_clk, .rst, .clk_en, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq,
	.sys_reset_req);

// ==== sim/window_guard_timer_tb_top.sv ====
/* Directed bench for the guard timer registers, warning and reset.
 Assumes wgt_pkg, wgt_top and the bound checker compile first. */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("Error %0t got %h exp %h", $time, a, e); end end
module window_guard_timer_tb_top
	import wgt_pkg::*;
;
	logic core_clk = 0, rst = 1, cpu_halted = 0, debug_freeze = 0;
	logic clk_en = 1;
	logic cyc = 0, stb = 0, we = 0, ack, irq, req;
	logic [4:0] adr = '0;
	logic [31:0] dat = '0, rdat, q;
	int fails = 0, tests_run = 0, n;
	wgt_top u_dut (.core_clk, .rst, .clk_en, .cpu_halted,
		.debug_freeze, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq, .sys_reset_req(req));
	initial forever #12.5 core_clk = ~core_clk;
	// Hold the request until ack is sampled, then release for a cycle
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask : bus
	// Bounded wait for the reset request or the interrupt
	task automatic await(input bit on_req);
		n = 0;
		while ((on_req ? req : irq) !== 1'b1 && n < 9000) begin
			@(posedge core_clk);
			n++;
		end
	endtask : await
	task automatic t_reset();
		bus(0, ADR_CONTROL, 0); `CHK(q, 32'h3fff)
		bus(0, ADR_CONFIG, 0); `CHK(q, 32'h3fff)
		bus(0, ADR_FLAGS, 0); `CHK(q, 32'h0)
		bus(0, 5'h14, 0); `CHK(q, 32'h0)
	endtask : t_reset
	task automatic t_freeze();
		{cpu_halted, debug_freeze} <= 2'b11;
		bus(1, ADR_CONTROL, 32'h41);
		repeat (9000) @(posedge core_clk);
		bus(0, ADR_CONTROL, 0); `CHK(q, 32'h41)
		{cpu_halted, debug_freeze} <= 2'b00;
	endtask : t_freeze
	task automatic t_early();
		bus(1, ADR_CONFIG, 32'h13fff);
		await(0); `CHK(irq, 1'b1)
		bus(0, ADR_FLAGS, 0); `CHK(q, 32'h1)
		bus(0, ADR_CONTROL, 0); `CHK(q, 32'h40)
		bus(1, ADR_FLAGS, 1);
		bus(0, ADR_FLAGS, 0); `CHK(q, 32'h1)
		bus(0, ADR_IRQ_STAT, 0); `CHK(q, 32'h1)
		bus(0, ADR_IRQ_STAT, 0); `CHK(q, 32'h0)
		bus(1, ADR_FLAGS, 0);
		bus(0, ADR_FLAGS, 0); `CHK(q, 32'h0)
		`CHK(irq, 1'b0)
		bus(1, ADR_IRQ_MASK, 7);
		bus(0, ADR_IRQ_MASK, 0); `CHK(q, 32'h7)
		bus(1, ADR_CONFIG, 32'h3fff);
		bus(0, ADR_CONFIG, 0); `CHK(q, 32'h13fff)
	endtask : t_early
	task automatic t_window();
		bus(1, ADR_CONTROL, 32'h7000); `CHK(req, 1'b0)
		bus(1, ADR_CONFIG, 32'h0100);
		bus(1, ADR_CONTROL, 32'h3000); `CHK(req, 1'b1)
		bus(0, ADR_CONTROL, 0); `CHK(q[14], 1'b1)
		`CHK(irq, 1'b1)
		bus(0, ADR_IRQ_STAT, 0); `CHK(q[1], 1'b1)
	endtask : t_window
	task automatic t_under();
		rst <= 1;
		repeat (3) @(posedge core_clk);
		rst <= 0;
		bus(1, ADR_CONTROL, 32'h4041);
		bus(1, ADR_CONTROL, 32'h0041); `CHK(req, 1'b0)
		await(1); `CHK(req, 1'b1)
		`CHK(n > 4094 && n < 8195, 1'b1)
		@(posedge core_clk);
		`CHK(req, 1'b0)
		bus(0, ADR_CONTROL, 0); `CHK(q, 32'h403f)
	endtask : t_under
	// Clock enable low must freeze the counter and its prescaler
	task automatic t_hold();
		bus(0, ADR_CONTROL, 0);
		n = q[13:0];
		clk_en <= 0;
		repeat (9000) @(posedge core_clk);
		clk_en <= 1;
		bus(0, ADR_CONTROL, 0);
		`CHK(n - q[13:0] < 2, 1'b1)
	endtask : t_hold
	// Slowdown 01: 12288 cycles hold one or two ticks, not three
	task automatic t_slow();
		bus(1, ADR_CONFIG, 32'h7fff);
		bus(1, ADR_CONTROL, 32'h0100);
		repeat (12288) @(posedge core_clk);
		bus(0, ADR_CONTROL, 0);
		`CHK(q[13:0] >= 14'h00fe && q[13:0] <= 14'h00ff, 1'b1)
	endtask : t_slow
	task automatic complete_run();
		$display("Checks %0d, errors %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 0;
		t_reset();
		t_freeze();
		t_early();
		t_window();
		t_under();
		t_hold();
		t_slow();
		complete_run();
	end
	// Whole run is near 43k cycles; this cuts a hang well beyond it
	initial begin
		#2000000;
		fails++;
		complete_run();
	end
endmodule : window_guard_timer_tb_top
